// [hw/spp_pkg.sv]
package spp_pkg;

    // Register bus geometry
    localparam int SPP_ADDR_W = 8;
    localparam logic [SPP_ADDR_W-1:0] SPP_ADDR_COMMAND = 8'h00;
    localparam logic [SPP_ADDR_W-1:0] SPP_ADDR_STATUS = 8'h04;

    // Selector field positions
    localparam int SPP_SEL_W = 8;
    localparam int SPP_SEL_MODEM_BIT = 0;
    localparam int SPP_SEL_PORT_BIT = 2;
    localparam int SPP_SEL_DIR_BIT = 7;

    // Named selector values of the five commands
    localparam logic [SPP_SEL_W-1:0] SPP_SEL_PORT_A_ON = 8'h04;
    localparam logic [SPP_SEL_W-1:0] SPP_SEL_PORT_A_ON_NO_MODEM = 8'h05;
    localparam logic [SPP_SEL_W-1:0] SPP_SEL_PORT_B_ON = 8'h00;
    localparam logic [SPP_SEL_W-1:0] SPP_SEL_PORT_A_OFF = 8'h84;
    localparam logic [SPP_SEL_W-1:0] SPP_SEL_PORT_B_OFF = 8'h80;

    // Status register field positions
    localparam int SPP_STAT_SCC_BIT = 0;
    localparam int SPP_STAT_NEG_BIT = 1;
    localparam int SPP_STAT_DRV_BIT = 2;
    localparam int SPP_STAT_MODEM_BIT = 3;
    localparam int SPP_STAT_A_USE_BIT = 4;
    localparam int SPP_STAT_B_USE_BIT = 5;
    localparam int SPP_STAT_PRESENT_BIT = 6;
    localparam int SPP_STAT_ON_A_BIT = 7;

    // In-use vector positions
    localparam int SPP_PORT_B_IDX = 0;
    localparam int SPP_PORT_A_IDX = 1;

    // Power enables for the four loads
    typedef struct packed {
        logic modem;
        logic drivers;
        logic negSupply;
        logic commCtrl;
    } spp_power_type;

    // Decoded command fields
    typedef struct packed {
        logic ignoreModem;
        logic portA;
        logic powerOff;
    } spp_cmd_type;

    // Reset values
    localparam spp_power_type SPP_POWER_RESET = 4'h0;
    localparam logic [1:0] SPP_IN_USE_RESET = 2'h0;
    localparam logic [SPP_SEL_W-1:0] SPP_SEL_RESET = 8'h00;

endpackage : spp_pkg

// [hw/spp_sync.sv]
`timescale 1ns/1ns
module spp_sync #(
    parameter int WIDTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Asynchronous levels in, clocked levels out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    import spp_pkg::*;

    // Refuse an empty synchroniser
    if (WIDTH < 1) begin : g_check
        $error("spp_sync needs WIDTH of at least one");
    end

    // Two flops per bit; first stage feeds only the second
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_q;
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                meta_q <= 1'b0;
                syncOut[i] <= 1'b0;
            end else begin
                meta_q <= asyncIn[i];
                syncOut[i] <= meta_q;
            end
        end
    end

endmodule : spp_sync

// [hw/spp_cmd_decode.sv]
`timescale 1ns/1ns
module spp_cmd_decode (
    // Raw selector byte
    input wire logic [spp_pkg::SPP_SEL_W-1:0] selector,
    // Decoded fields
    output spp_pkg::spp_cmd_type cmd
);
    import spp_pkg::*;

    // Only bits 0, 2 and 7 matter; the rest are dropped here
    always_comb begin
        cmd.ignoreModem = selector[SPP_SEL_MODEM_BIT];
        cmd.portA = selector[SPP_SEL_PORT_BIT];
        cmd.powerOff = selector[SPP_SEL_DIR_BIT];
    end

endmodule : spp_cmd_decode

// [hw/spp_power_switch.sv]
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ns
module spp_power_switch #(
    parameter int DATA_W = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [spp_pkg::SPP_ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdData,
    // Modem straps from the board
    input wire logic modemPresent,
    input wire logic modemOnPortA,
    // Load enables
    output spp_pkg::spp_power_type powerEn
);
    import spp_pkg::*;

    // The status byte must fit the data bus
    if (DATA_W < SPP_SEL_W) begin : g_check
        $error("spp_power_switch needs DATA_W of at least eight");
    end

    // Synchronised straps
    logic [1:0] strapSync;
    // Modem present, clocked
    logic presentSync;
    // Modem wired to port A, clocked
    logic onPortASync;
    // Command written this cycle
    logic cmdExec;
    // Selector byte from the bus
    logic [SPP_SEL_W-1:0] selNow;
    // Decoded command
    spp_cmd_type cmd;
    // Modem usable by port A
    logic modemForA;
    // Modem usable by port B
    logic modemForB;
    // Load enables and next value
    spp_power_type power_q;
    spp_power_type power_d;
    // Per-port in-use and next value
    logic [1:0] inUse_q;
    logic [1:0] inUse_d;
    // Last selector accepted
    logic [SPP_SEL_W-1:0] lastSel_q;
    // Read data and next value
    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] rdData_d;
    // Status byte as seen by software
    logic [SPP_SEL_W-1:0] statusByte;

    // Straps come from pins, so two flops first
    spp_sync #(
        .WIDTH(2)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .asyncIn({modemOnPortA, modemPresent}),
        .syncOut(strapSync)
    );

    assign presentSync = strapSync[0];
    assign onPortASync = strapSync[1];

    // Decode selector fields
    assign selNow = regWrData[SPP_SEL_W-1:0];

    spp_cmd_decode u_decode (
        .selector(selNow),
        .cmd(cmd)
    );

    // A write to the command word is the only trigger
    assign cmdExec = regWrite && (regAddr == SPP_ADDR_COMMAND);

    // Modem attachment as the two ports see it
    assign modemForA = presentSync && onPortASync;
    assign modemForB = presentSync && !onPortASync;

    // Next load enables
    always_comb begin
        power_d = power_q;
        if (cmdExec) begin
            unique case ({cmd.powerOff, cmd.portA})
                // Port A on
                2'b01: begin
                    power_d.commCtrl = 1'b1;
                    power_d.negSupply = 1'b1;
                    if (!cmd.ignoreModem && modemForA) begin
                        power_d.modem = 1'b1;
                    end else begin
                        power_d.drivers = 1'b1;
                    end
                end
                // Port B on
                2'b00: begin
                    power_d.commCtrl = 1'b1;
                    power_d.negSupply = 1'b1;
                    power_d.drivers = 1'b1;
                end
                // Port A off
                2'b11: begin
                    if (!inUse_q[SPP_PORT_B_IDX]) begin
                        power_d.commCtrl = 1'b0;
                        power_d.negSupply = 1'b0;
                    end
                    if (!cmd.ignoreModem && modemForA && power_q.modem) begin
                        power_d.modem = 1'b0;
                    end else if (!inUse_q[SPP_PORT_B_IDX]) begin
                        power_d.drivers = 1'b0;
                    end
                end
                // Port B off
                2'b10: begin
                    if (!inUse_q[SPP_PORT_A_IDX]) begin
                        power_d.commCtrl = 1'b0;
                        power_d.negSupply = 1'b0;
                    end
                    if (!cmd.ignoreModem && modemForB && power_q.modem) begin
                        power_d.modem = 1'b0;
                    end else if (!inUse_q[SPP_PORT_A_IDX]) begin
                        power_d.drivers = 1'b0;
                    end
                end
            endcase
        end
    end

    // Load enable register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            power_q <= SPP_POWER_RESET;
        end else begin
            power_q <= power_d;
        end
    end

    // Next in-use flags
    always_comb begin
        inUse_d = inUse_q;
        if (cmdExec) begin
            if (cmd.portA) begin
                inUse_d[SPP_PORT_A_IDX] = !cmd.powerOff;
            end else begin
                inUse_d[SPP_PORT_B_IDX] = !cmd.powerOff;
            end
        end
    end

    // In-use register; only commands touch it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            inUse_q <= SPP_IN_USE_RESET;
        end else begin
            inUse_q <= inUse_d;
        end
    end

    // Keep the last selector for read-back
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lastSel_q <= SPP_SEL_RESET;
        end else if (cmdExec) begin
            lastSel_q <= selNow;
        end
    end

    // Status byte layout
    always_comb begin
        statusByte = '0;
        statusByte[SPP_STAT_SCC_BIT] = power_q.commCtrl;
        statusByte[SPP_STAT_NEG_BIT] = power_q.negSupply;
        statusByte[SPP_STAT_DRV_BIT] = power_q.drivers;
        statusByte[SPP_STAT_MODEM_BIT] = power_q.modem;
        statusByte[SPP_STAT_A_USE_BIT] = inUse_q[SPP_PORT_A_IDX];
        statusByte[SPP_STAT_B_USE_BIT] = inUse_q[SPP_PORT_B_IDX];
        statusByte[SPP_STAT_PRESENT_BIT] = presentSync;
        statusByte[SPP_STAT_ON_A_BIT] = onPortASync;
    end

    // Read mux; unmapped and idle cycles give zero
    always_comb begin
        rdData_d = '0;
        if (regRead) begin
            if (regAddr == SPP_ADDR_COMMAND) begin
                rdData_d = DATA_W'(lastSel_q);
            end else if (regAddr == SPP_ADDR_STATUS) begin
                rdData_d = DATA_W'(statusByte);
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdData_q <= '0;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    // Outputs straight from flops
    assign regRdData = rdData_q;
    assign powerEn = power_q;

    // Port A on powers shared loads
    AST_A_ON_SHARED: assert property (@(posedge clk) disable iff (reset)
        cmdExec && selNow == SPP_SEL_PORT_A_ON
        |=> power_q.commCtrl && power_q.negSupply)
        else $error("port A on left shared loads off");

    // Attached modem comes up with port A
    AST_A_ON_MODEM: assert property (@(posedge clk) disable iff (reset)
        cmdExec && selNow == SPP_SEL_PORT_A_ON && modemForA
        |=> power_q.modem && $stable(power_q.drivers))
        else $error("port A on did not power the modem");

    // Without modem, drivers come up
    AST_A_ON_DRIVERS: assert property (@(posedge clk) disable iff (reset)
        cmdExec && selNow == SPP_SEL_PORT_A_ON && !modemForA
        |=> power_q.drivers && $stable(power_q.modem))
        else $error("port A on did not power the drivers");

    // Ignore-modem variant never raises modem
    AST_A_ON_NO_MODEM: assert property (@(posedge clk) disable iff (reset)
        cmdExec && selNow == SPP_SEL_PORT_A_ON_NO_MODEM
        |=> power_q.drivers && power_q.commCtrl && $stable(power_q.modem))
        else $error("ignore-modem command touched the modem");

    // Port B on powers three loads and marks B busy on the same edge
    AST_B_ON: assert property (@(posedge clk) disable iff (reset)
        cmdExec && selNow == SPP_SEL_PORT_B_ON
        |=> power_q.commCtrl && power_q.negSupply && power_q.drivers
            && inUse_q[SPP_PORT_B_IDX])
        else $error("port B on incomplete");

    // Port A off keeps shared loads while B is busy
    AST_A_OFF_SHARED: assert property (@(posedge clk) disable iff (reset)
        cmdExec && selNow == SPP_SEL_PORT_A_OFF
        |=> power_q.commCtrl == ($past(power_q.commCtrl) && $past(inUse_q[SPP_PORT_B_IDX])))
        else $error("port A off mishandled the controller");

    // Port A off drops a powered modem on A
    AST_A_OFF_MODEM: assert property (@(posedge clk) disable iff (reset)
        cmdExec && selNow == SPP_SEL_PORT_A_OFF && modemForA && power_q.modem
        |=> !power_q.modem && $stable(power_q.drivers))
        else $error("port A off kept the modem powered");

    // Port A off drivers follow B usage
    AST_A_OFF_DRIVERS: assert property (@(posedge clk) disable iff (reset)
        cmdExec && selNow == SPP_SEL_PORT_A_OFF && !(modemForA && power_q.modem)
        |=> power_q.drivers == ($past(power_q.drivers) && $past(inUse_q[SPP_PORT_B_IDX])))
        else $error("port A off mishandled the drivers");

    // Port B off keeps shared loads while A is busy
    AST_B_OFF_SHARED: assert property (@(posedge clk) disable iff (reset)
        cmdExec && selNow == SPP_SEL_PORT_B_OFF
        |=> power_q.negSupply == ($past(power_q.negSupply) && $past(inUse_q[SPP_PORT_A_IDX])))
        else $error("port B off mishandled the negative supply");

    // Port B off drops a powered modem on B
    AST_B_OFF_MODEM: assert property (@(posedge clk) disable iff (reset)
        cmdExec && selNow == SPP_SEL_PORT_B_OFF && modemForB && power_q.modem
        |=> !power_q.modem)
        else $error("port B off kept the modem powered");

    // Port B off drivers follow A usage
    AST_B_OFF_DRIVERS: assert property (@(posedge clk) disable iff (reset)
        cmdExec && selNow == SPP_SEL_PORT_B_OFF && !(modemForB && power_q.modem)
        |=> power_q.drivers == ($past(power_q.drivers) && $past(inUse_q[SPP_PORT_A_IDX])))
        else $error("port B off mishandled the drivers");

    // In-use for A follows the A commands
    AST_IN_USE_A: assert property (@(posedge clk) disable iff (reset)
        cmdExec && cmd.portA
        |=> inUse_q[SPP_PORT_A_IDX] == !$past(cmd.powerOff)
            && $stable(inUse_q[SPP_PORT_B_IDX]))
        else $error("port A in-use flag wrong");

    // In-use for B follows the B commands
    AST_IN_USE_B: assert property (@(posedge clk) disable iff (reset)
        cmdExec && !cmd.portA
        |=> inUse_q[SPP_PORT_B_IDX] == !$past(cmd.powerOff)
            && $stable(inUse_q[SPP_PORT_A_IDX]))
        else $error("port B in-use flag wrong");

    // Off with the ignore bit leaves the modem alone
    AST_OFF_IGNORE: assert property (@(posedge clk) disable iff (reset)
        cmdExec && cmd.powerOff && cmd.ignoreModem
        |=> $stable(power_q.modem))
        else $error("ignore bit did not protect the modem");

    // Port B on never raises the modem, only drivers
    AST_B_ON_MODEM: assert property (@(posedge clk) disable iff (reset)
        cmdExec && !cmd.powerOff && !cmd.portA
        |=> $stable(power_q.modem))
        else $error("port B on touched the modem");

    // Off commands never switch a load on
    AST_OFF_NO_RAISE: assert property (@(posedge clk) disable iff (reset)
        cmdExec && cmd.powerOff
        |=> (4'(power_q) & ~4'($past(power_q))) == 4'h0)
        else $error("off command raised a load");

    // On commands never switch a load off
    AST_ON_NO_DROP: assert property (@(posedge clk) disable iff (reset)
        cmdExec && !cmd.powerOff
        |=> (4'($past(power_q)) & ~4'(power_q)) == 4'h0)
        else $error("on command dropped a load");

    // Nothing moves without a command
    AST_HOLD: assert property (@(posedge clk) disable iff (reset)
        !cmdExec |=> $stable(power_q) && $stable(inUse_q))
        else $error("enables changed without a command");

    // Read data only after a strobe
    AST_READ_SLOT: assert property (@(posedge clk) disable iff (reset)
        !regRead |=> rdData_q == '0)
        else $error("read data outside its slot");

endmodule : spp_power_switch

// [tb/spp_host_model.sv]
`timescale 1ns/1ns
module spp_host_model (
    // Clock
    input wire logic clk,
    // Register port toward the block
    output logic [spp_pkg::SPP_ADDR_W-1:0] regAddr,
    output logic [31:0] regWrData,
    output logic regWrite,
    output logic regRead,
    // Read data from the block
    input wire logic [31:0] regRdData
);
    import spp_pkg::*;

    // Idle bus at time zero
    initial begin
        regAddr = 8'h00;
        regWrData = 32'h0000_0000;
        regWrite = 1'b0;
        regRead = 1'b0;
    end

    // One-cycle write, launched just after an edge
    task automatic write_reg(input logic [7:0] addr, input logic [31:0] data);
        @(posedge clk);
        regAddr <= addr;
        regWrData <= data;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        // Inverted idle data so a stale word never looks like a command
        regWrData <= ~data;
    endtask : write_reg

    // One-cycle read; data is only valid in the following cycle
    task automatic read_reg(input logic [7:0] addr, output logic [31:0] data);
        @(posedge clk);
        regAddr <= addr;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        data = regRdData;
    endtask : read_reg

    // Selector built from its three meaningful bits
    task automatic send_cmd(input logic portA, input logic off, input logic skipModem);
        logic [7:0] sel;
        sel = 8'h00;
        sel[SPP_SEL_MODEM_BIT] = skipModem;
        sel[SPP_SEL_PORT_BIT] = portA;
        sel[SPP_SEL_DIR_BIT] = off;
        write_reg(SPP_ADDR_COMMAND, {24'h00_0000, sel});
    endtask : send_cmd

endmodule : spp_host_model

// [tb/spp_power_switch_tb.sv]
`timescale 1ns/1ns
module spp_power_switch_tb;
    import spp_pkg::*;

    // Clock, reset and board straps
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic modemPresent = 1'b0;
    logic modemOnPortA = 1'b0;
    // Register port
    logic [SPP_ADDR_W-1:0] regAddr;
    logic [31:0] regWrData;
    logic regWrite;
    logic regRead;
    logic [31:0] regRdData;
    // Load enables
    spp_power_type powerEn;
    // Scoreboard
    int miscompares = 0;
    int cmp_count = 0;
    logic [31:0] rd;

    // 125 MHz clock
    always #4 clk = ~clk;

    spp_power_switch #(.DATA_W(32)) dut (
        .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .modemPresent(modemPresent), .modemOnPortA(modemOnPortA), .powerEn(powerEn)
    );

    spp_host_model host (
        .clk(clk), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData)
    );

    // Verdict and end of run
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // Single compare with report
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Enables compared once the launching edge has settled
    task automatic pw(input string what, input logic [3:0] exp);
        @(negedge clk);
        chk(what, {28'h000_0000, exp}, {28'h000_0000, powerEn});
    endtask : pw

    // Straps need two flops of sync before commands see them
    task automatic straps(input logic present, input logic onA);
        @(posedge clk);
        modemPresent <= present;
        modemOnPortA <= onA;
        repeat (3) @(posedge clk);
    endtask : straps

    // Reset values, then a reset in mid-run
    task automatic t_reset;
        pw("power after reset", 4'h0);
        host.read_reg(SPP_ADDR_STATUS, rd);
        chk("status after reset", 32'h0000_0000, rd);
        host.send_cmd(1'b0, 1'b0, 1'b0);
        pw("b on", 4'h7);
        @(posedge clk);
        reset <= 1'b1;
        pw("power in reset", 4'h0);
        @(posedge clk);
        reset <= 1'b0;
        host.read_reg(SPP_ADDR_STATUS, rd);
        chk("status after second reset", 32'h0000_0000, rd);
        $display("test reset done");
    endtask : t_reset

    // Port A on and off with the modem on A, then without a usable modem
    task automatic t_port_a;
        straps(1'b1, 1'b1);
        host.send_cmd(1'b1, 1'b0, 1'b0);
        pw("a on with modem", 4'hB);
        host.send_cmd(1'b1, 1'b1, 1'b0);
        pw("a off with modem", 4'h0);
        straps(1'b1, 1'b0);
        host.send_cmd(1'b1, 1'b0, 1'b0);
        pw("a on modem on b", 4'h7);
        host.send_cmd(1'b1, 1'b1, 1'b0);
        pw("a off drivers", 4'h0);
        straps(1'b0, 1'b1);
        host.send_cmd(1'b1, 1'b0, 1'b0);
        pw("a on no modem", 4'h7);
        host.send_cmd(1'b1, 1'b1, 1'b0);
        pw("a off no modem", 4'h0);
        $display("test port a done");
    endtask : t_port_a

    // Ignore-modem command never powers the modem
    task automatic t_ignore;
        straps(1'b1, 1'b1);
        host.send_cmd(1'b1, 1'b0, 1'b1);
        pw("a on ignore modem", 4'h7);
        host.read_reg(SPP_ADDR_COMMAND, rd);
        chk("command readback", 32'h0000_0005, rd);
        host.read_reg(SPP_ADDR_STATUS, rd);
        chk("status ignore", 32'h0000_00D7, rd);
        host.send_cmd(1'b1, 1'b1, 1'b0);
        pw("a off after ignore", 4'h0);
        host.send_cmd(1'b1, 1'b0, 1'b0);
        pw("a on modem again", 4'hB);
        host.send_cmd(1'b1, 1'b1, 1'b1);
        pw("a off ignore keeps modem", 4'h8);
        host.send_cmd(1'b1, 1'b1, 1'b0);
        pw("a off drops modem", 4'h0);
        $display("test ignore done");
    endtask : t_ignore

    // Shared loads held while the other port still uses them
    task automatic t_shared;
        host.send_cmd(1'b0, 1'b0, 1'b0);
        pw("b on", 4'h7);
        host.read_reg(SPP_ADDR_STATUS, rd);
        chk("status b busy", 32'h0000_00E7, rd);
        host.send_cmd(1'b1, 1'b0, 1'b0);
        pw("a on beside b", 4'hF);
        host.send_cmd(1'b1, 1'b1, 1'b0);
        pw("a off b busy", 4'h7);
        host.send_cmd(1'b0, 1'b1, 1'b0);
        pw("b off a idle", 4'h0);
        straps(1'b0, 1'b1);
        host.send_cmd(1'b1, 1'b0, 1'b0);
        host.send_cmd(1'b0, 1'b0, 1'b0);
        host.send_cmd(1'b0, 1'b1, 1'b0);
        pw("b off a busy", 4'h7);
        host.send_cmd(1'b1, 1'b1, 1'b0);
        pw("a off last", 4'h0);
        $display("test shared done");
    endtask : t_shared

    // Modem moved to port B while powered, then port B off
    task automatic t_b_modem;
        straps(1'b1, 1'b1);
        host.send_cmd(1'b1, 1'b0, 1'b0);
        pw("a on modem", 4'hB);
        straps(1'b1, 1'b0);
        host.send_cmd(1'b0, 1'b1, 1'b0);
        pw("b off drops modem", 4'h3);
        host.send_cmd(1'b1, 1'b1, 1'b0);
        pw("a off rest", 4'h0);
        $display("test b modem done");
    endtask : t_b_modem

    // Stray selector bits, status and unmapped writes, stable enables
    task automatic t_misc;
        straps(1'b0, 1'b1);
        host.write_reg(SPP_ADDR_COMMAND, 32'hA5A5_A57E);
        pw("a on stray bits", 4'h7);
        host.read_reg(SPP_ADDR_COMMAND, rd);
        chk("command low byte", 32'h0000_007E, rd);
        host.read_reg(SPP_ADDR_STATUS, rd);
        chk("status a on", 32'h0000_0097, rd);
        host.write_reg(SPP_ADDR_STATUS, 32'h0000_0084);
        host.write_reg(8'h10, 32'h0000_0084);
        host.read_reg(8'h10, rd);
        chk("unmapped read", 32'h0000_0000, rd);
        repeat (4) pw("enables held", 4'h7);
        host.send_cmd(1'b1, 1'b1, 1'b0);
        pw("a off final", 4'h0);
        $display("test misc done");
    endtask : t_misc

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_port_a();
        t_ignore();
        t_shared();
        t_b_modem();
        t_misc();
        close_out();
    end

    // Watchdog at 3000 cycles, well beyond the fewer than two hundred cycles the tests need
    initial begin
        #(3000 * 8);
        miscompares++;
        close_out();
    end

endmodule : spp_power_switch_tb
